/* bench/hpcs_far_model.sv */
// Purpose: Cable presence of the upstream host and the management host
// Assumes: Cables are plugged only between tests
// Notes: plug[0] upstream zero bus power, plug[1] control cable
`timescale 1ns/10ps
module hpcs_far_model (
  input wire logic [1:0] plug,
  output logic upstream0_vbus_present,
  output logic control_cable_present
);
  assign upstream0_vbus_present = plug[0];
  assign control_cable_present = plug[1];
endmodule // hpcs_far_model

/* bench/hpcs_top_checker.sv */
// Purpose: Port-level properties of hpcs_top
// Assumes: Single-strobe reads unless a property says otherwise
// Notes: Waits three edges after reset so the internal reset has let go
`timescale 1ns/10ps
module hpcs_top_checker
  import hpcs_pkg::*;
#(
  parameter int unsigned TEMP_W = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic control_cable_present,
  input wire logic upstream0_vbus_present,
  input wire logic write_upstream_selection,
  input wire logic read_upstream_selection,
  input wire logic bank_index,
  input wire logic write_port_enable_word,
  input wire logic read_port_enable_word,
  input wire logic read_port_state_bank,
  input wire logic read_overcurrent_bank,
  input wire logic read_subsystem_temperature,
  input wire logic [7:0] upstream_sel_wdata,
  input wire logic [31:0] enable_wdata,
  input wire logic signed [TEMP_W-1:0] temperature_micro_c,
  input wire hpcs_chan_status_t chan_status,
  input wire hpcs_chan_enable_t chan_enable,
  input wire logic upstream0_connect,
  input wire logic upstream1_connect,
  input wire logic rdata_valid,
  input wire logic mgmt_via_control_port,
  input wire logic mgmt_via_upstream0,
  input wire logic mgmt_via_upstream1,
  input wire logic [31:0] rdata
);
  logic [1:0] up_r;
  wire logic live = (up_r == 2'h3);
  wire logic hi3 = read_upstream_selection | read_port_enable_word | read_port_state_bank;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) up_r <= 2'h0;
    else if (!live) up_r <= up_r + 2'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_mgmt_ctrl;
    live && control_cable_present |->
      mgmt_via_control_port && !mgmt_via_upstream0 && !mgmt_via_upstream1;
  endproperty
  a_mgmt_ctrl: assert property (p_mgmt_ctrl) else $error("control port routing");
  property p_mgmt_up;
    live && !control_cable_present |-> !mgmt_via_control_port &&
      mgmt_via_upstream0 == upstream0_connect && mgmt_via_upstream1 == upstream1_connect;
  endproperty
  a_mgmt_up: assert property (p_mgmt_up) else $error("upstream management routing");
  property p_one_up;
    live |-> !(upstream0_connect && upstream1_connect);
  endproperty
  a_one_up: assert property (p_one_up) else $error("both upstreams connected");
  property p_disc;
    live && clk_en && write_upstream_selection && upstream_sel_wdata == UP_SEL_DISCONNECT
      |=> !upstream0_connect && !upstream1_connect;
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect ignored");
  property p_auto;
    live && clk_en && write_upstream_selection && upstream_sel_wdata == UP_SEL_AUTOMATIC
      |=> upstream0_connect == upstream0_vbus_present && upstream1_connect != upstream0_connect;
  endproperty
  a_auto: assert property (p_auto) else $error("automatic pick wrong");
  property p_valid;
    live && clk_en && (read_port_enable_word || read_subsystem_temperature) |=> rdata_valid;
  endproperty
  a_valid: assert property (p_valid) else $error("read answer missing");
  property p_word;
    live && clk_en && write_port_enable_word |=>
      chan_enable.hs_data_en[0] == $past(enable_wdata[0])
      && chan_enable.vbus_en[7] == $past(enable_wdata[15])
      && chan_enable.ss_data_en[7] == $past(enable_wdata[30]);
  endproperty
  a_word: assert property (p_word) else $error("enable word mapping");
  property p_rsvd;
    live && clk_en && write_port_enable_word ##1 clk_en && read_port_enable_word &&
      !read_upstream_selection |=> (rdata & ENABLE_WORD_RSVD) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved enable bits set");
  property p_sticky;
    live && clk_en && chan_status.overcurrent[1] ##1 clk_en && read_overcurrent_bank &&
      !bank_index && !hi3 |=> rdata[8];
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag lost");
  property p_temp;
    live && clk_en && read_subsystem_temperature && !hi3 && !read_overcurrent_bank
      |=> rdata == 32'($past(temperature_micro_c));
  endproperty
  a_temp: assert property (p_temp) else $error("temperature read wrong");
endmodule // hpcs_top_checker
bind hpcs_top hpcs_top_checker #(.TEMP_W(TEMP_W)) u_chk (.*);

/* bench/tb_top.sv */
// Purpose: Self-checking bench for hpcs_top
// Assumes: Inputs change at the falling edge
// Notes: Strobe bits: 0 wr sel,1 rd sel,2 wr en,3 rd en,4 state,5 oc,6 clear,7 temp
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb_top;
  import hpcs_pkg::*;
  typedef struct packed {
    logic [7:0] code;
    logic [1:0] plug;
    logic [4:0] ex;
    logic [7:0] rb;
  } hpcs_row_t;
  logic sys_clk = 0, reset_n = 0, clk_en = 1, bank = 0, u0, u1, cp, m0, m1, vld;
  logic [7:0] st = '0, sel = '0;
  logic [1:0] plug = '0;
  logic [2:0] chn = '0;
  logic [31:0] wd = '0, rdata;
  logic signed [31:0] temp = -32'sd5;
  hpcs_chan_status_t cs = '0;
  hpcs_chan_enable_t ce;
  wire logic vbus0, cab;
  int fail_count = 0, compares = 0;
  hpcs_row_t rows [6] = '{'{8'h00, 2'b00, 5'b10010, 8'h00}, '{8'h01, 2'b10, 5'b01100, 8'h01},
    '{8'h02, 2'b01, 5'b10010, 8'h02}, '{8'h02, 2'b00, 5'b01001, 8'h02},
    '{8'hff, 2'b01, 5'b00000, 8'hff}, '{8'h07, 2'b00, 5'b00000, 8'hff}};
  always #2 sys_clk = ~sys_clk;
  hpcs_far_model far (.plug(plug), .upstream0_vbus_present(vbus0), .control_cable_present(cab));
  hpcs_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .upstream_sel_wdata(sel), .write_upstream_selection(st[0]), .read_upstream_selection(st[1]),
    .enable_wdata(wd), .write_port_enable_word(st[2]), .read_port_enable_word(st[3]),
    .read_port_state_bank(st[4]), .read_overcurrent_bank(st[5]), .bank_index(bank),
    .clear_channel_errors(st[6]), .clear_channel(chn), .read_subsystem_temperature(st[7]),
    .temperature_micro_c(temp), .upstream0_vbus_present(vbus0), .control_cable_present(cab),
    .chan_status(cs), .chan_enable(ce), .upstream0_connect(u0), .upstream1_connect(u1),
    .mgmt_via_control_port(cp), .mgmt_via_upstream0(m0), .mgmt_via_upstream1(m1),
    .rdata(rdata), .rdata_valid(vld));
  task automatic rd(input logic [7:0] k, input logic [31:0] e);
    st = k;
    @(negedge sys_clk);
    st = '0;
    `CHK(vld, 1'b1)
    `CHK(rdata, e)
    @(negedge sys_clk);
  endtask
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2000;
    fail_count++;
    results();
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    reset_n = 1;
    repeat (3) @(negedge sys_clk);
    rd(8'h02, 32'h0000_0002);
    foreach (rows[i]) begin
      plug = rows[i].plug;
      sel = rows[i].code;
      st = 8'h01;
      @(negedge sys_clk);
      `CHK({u0, u1, cp, m0, m1}, rows[i].ex)
      rd(8'h02, {24'h0, rows[i].rb});
    end
    wd = 32'hffff_ffff;
    st = 8'h04;
    @(negedge sys_clk);
    st = 8'h08;
    @(negedge sys_clk);
    st = '0;
    `CHK(rdata, 32'h5555_ffff)
    `CHK(ce, {8'hff, 8'hff, 8'hff})
    cs = '{8'h22, 8'h02, 8'h00, 8'h02};
    @(negedge sys_clk);
    cs.overcurrent = '0;
    rd(8'h20, 32'h0000_0100);
    rd(8'h10, 32'h0000_1900);
    bank = 1;
    rd(8'h10, 32'h0000_0100);
    bank = 0;
    chn = 3'h1;
    st = 8'h40;
    @(negedge sys_clk);
    rd(8'h10, 32'h0000_1100);
    rd(8'h20, 32'h0000_0000);
    rd(8'h80, 32'hffff_fffb);
    // A write while the clock enable is low must leave the word untouched
    clk_en = 1'b0;
    wd = 32'h0000_0000;
    st = 8'h04;
    @(negedge sys_clk);
    clk_en = 1'b1;
    rd(8'h08, 32'h5555_ffff);
    // Second reset in mid-run: everything back to its reset value
    reset_n = 1'b0;
    @(negedge sys_clk);
    `CHK({u0, u1, vld, rdata}, 35'h0)
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK({u0, u1}, 2'b01)
    rd(8'h02, 32'h0000_0002);
    rd(8'h08, 32'h0000_0000);
    results();
  end
endmodule // tb_top

/* core/hpcs_pkg.sv */
// Purpose: Shared constants and carrier types for the hub port control block
// Assumes: Eight downstream channels, two upstream ports, one control port
// Notes: Commands arrive as one-cycle strobes, not over a bus
package hpcs_pkg;
  localparam int unsigned NUM_CHANNELS = 8;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CH_PER_BANK = 4;
  // Upstream selection codes
  localparam logic [7:0] UP_SEL_FIRST = 8'h00;
  localparam logic [7:0] UP_SEL_SECOND = 8'h01;
  localparam logic [7:0] UP_SEL_AUTOMATIC = 8'h02;
  localparam logic [7:0] UP_SEL_DISCONNECT = 8'hff;
  localparam logic [7:0] UP_SEL_RESET = UP_SEL_AUTOMATIC;
  // Field positions
  localparam int unsigned HS_BIT = 0;
  localparam int unsigned PWR_BIT = 1;
  localparam int unsigned SS_BASE = 16;
  localparam int unsigned ST_ATTACHED = 0;
  localparam int unsigned ST_ERROR = 3;
  localparam int unsigned ST_HIGH_SPEED = 4;
  localparam int unsigned ST_SUPER_SPEED = 5;
  localparam int unsigned OC_LIMIT = 0;
  localparam logic [31:0] ENABLE_WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_WORD_RSVD = 32'haaaa_0000;

  typedef enum logic [1:0] {
    HPCS_UP_NONE,
    HPCS_UP_FIRST,
    HPCS_UP_SECOND
  } hpcs_upstream_t;

  typedef struct packed {
    logic [NUM_CHANNELS-1:0] attached;
    logic [NUM_CHANNELS-1:0] high_speed;
    logic [NUM_CHANNELS-1:0] super_speed;
    logic [NUM_CHANNELS-1:0] overcurrent;
  } hpcs_chan_status_t;

  typedef struct packed {
    logic [NUM_CHANNELS-1:0] hs_data_en;
    logic [NUM_CHANNELS-1:0] vbus_en;
    logic [NUM_CHANNELS-1:0] ss_data_en;
  } hpcs_chan_enable_t;
endpackage

/* core/hpcs_top.sv */
// Purpose: Upstream routing, management routing and per-channel control/status
// Assumes: Command strobes and status inputs are synchronous to sys_clk
// Notes: Every command is a one-cycle strobe; read data is registered
`timescale 1ns/10ps

// Operation
// - Code 0 picks upstream zero, 1 upstream one
// - Code 2 selects upstream port automatically
// - Code 255 disconnects both upstream ports
// - Selection resets to automatic
// - Auto: upstream-zero bus power selects port zero
// - Control port carries management, never hub traffic
// - Control cable present: manage only through it
// - No control cable: manage through selected upstream
// - Whole enable word read/written at once
// - Bits 2n/2n+1: channel high-speed, power
// - Bits 16+2n SuperSpeed enable; odd reserved
// - Two state banks, four channels each
// - State byte: attach, error, HS, SS bits
// - Two over-current banks, bit zero per byte
// - Clear resets channel error and over-current bits
// - Temperature reported in micro-degrees Celsius
module hpcs_top #(
  parameter int unsigned TEMP_W = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] upstream_sel_wdata,
  input wire logic write_upstream_selection,
  input wire logic read_upstream_selection,
  input wire logic [31:0] enable_wdata,
  input wire logic write_port_enable_word,
  input wire logic read_port_enable_word,
  input wire logic read_port_state_bank,
  input wire logic read_overcurrent_bank,
  input wire logic bank_index,
  input wire logic clear_channel_errors,
  input wire logic [2:0] clear_channel,
  input wire logic read_subsystem_temperature,
  input wire logic signed [TEMP_W-1:0] temperature_micro_c,
  input wire logic upstream0_vbus_present,
  input wire logic control_cable_present,
  input wire hpcs_pkg::hpcs_chan_status_t chan_status,
  output hpcs_pkg::hpcs_chan_enable_t chan_enable,
  output logic upstream0_connect,
  output logic upstream1_connect,
  output logic mgmt_via_control_port,
  output logic mgmt_via_upstream0,
  output logic mgmt_via_upstream1,
  output logic [31:0] rdata,
  output logic rdata_valid
);
  import hpcs_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The read word is only 32 bits wide, so a wider reading cannot be carried
  if (TEMP_W < 1 || TEMP_W > WORD_W) begin : g_bad_temp_w
    $error("TEMP_W must be 1 to 32");
  end
  // The bank and enable word layouts assume eight channels in two banks
  if (NUM_CHANNELS != 2 * CH_PER_BANK || SS_BASE + 2 * NUM_CHANNELS > WORD_W) begin : g_bad_geom
    $error("channel layout does not fit the 32-bit words");
  end

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  // Upstream selection group
  logic [7:0] up_sel_r;
  logic [7:0] up_sel_nxt;
  logic up_code_ok;
  // Enable word group
  logic [WORD_W-1:0] enable_word_r;
  logic [WORD_W-1:0] enable_word_nxt;
  // Over-current flag group
  logic [NUM_CHANNELS-1:0] oc_flag_r;
  logic [NUM_CHANNELS-1:0] oc_flag_nxt;
  logic [NUM_CHANNELS-1:0] clr_mask;
  // Read data group
  typedef enum logic [2:0] {
    HPCS_RD_IDLE,
    HPCS_RD_SELECTION,
    HPCS_RD_ENABLE,
    HPCS_RD_STATE,
    HPCS_RD_OVERCURRENT,
    HPCS_RD_TEMPERATURE
  } hpcs_read_src_t;
  hpcs_read_src_t rd_src;
  logic [WORD_W-1:0] temp_word;
  logic [WORD_W-1:0] rdata_r;
  logic [WORD_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  // Packed bank views, one word per bank
  logic [WORD_W-1:0] state_bank [2];
  logic [WORD_W-1:0] oc_bank [2];

  // One clear decode per channel, and the packed bank views per channel
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
    localparam int unsigned BK = ch / CH_PER_BANK;
    localparam int unsigned BY = (ch % CH_PER_BANK) * 8;
    assign clr_mask[ch] = clear_channel_errors && (clear_channel == 3'(ch));
    assign chan_enable.hs_data_en[ch] = enable_word_r[2*ch + HS_BIT];
    assign chan_enable.vbus_en[ch] = enable_word_r[2*ch + PWR_BIT];
    assign chan_enable.ss_data_en[ch] = enable_word_r[SS_BASE + 2*ch];
    assign state_bank[BK][BY +: 8] = {2'h0,
                                      chan_status.super_speed[ch],
                                      chan_status.high_speed[ch],
                                      oc_flag_r[ch],
                                      2'h0,
                                      chan_status.attached[ch]};
    assign oc_bank[BK][BY +: 8] = {7'h00, oc_flag_r[ch]};
  end

  // ----------------------------------------
  // Upstream selection register
  // ----------------------------------------
  // Undefined codes are dropped so routing never enters an unknown mode
  always_comb begin
    up_code_ok = 1'b0;
    case (upstream_sel_wdata)
      UP_SEL_FIRST: up_code_ok = 1'b1;
      UP_SEL_SECOND: up_code_ok = 1'b1;
      UP_SEL_AUTOMATIC: up_code_ok = 1'b1;
      UP_SEL_DISCONNECT: up_code_ok = 1'b1;
      default: up_code_ok = 1'b0;
    endcase
    up_sel_nxt = up_sel_r;
    if (write_upstream_selection && up_code_ok) begin
      up_sel_nxt = upstream_sel_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_sel_r <= UP_SEL_RESET;
    end else if (clk_en) begin
      up_sel_r <= up_sel_nxt;
    end
  end

  // ----------------------------------------
  // Hub port enable word
  // ----------------------------------------
  // One write replaces the word, so every channel switches on the same edge
  always_comb begin
    enable_word_nxt = enable_word_r;
    if (write_port_enable_word) begin
      // Reserved odd bits above 16 are forced low so they read back as zero
      enable_word_nxt = enable_wdata & ~ENABLE_WORD_RSVD;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_word_r <= ENABLE_WORD_RESET;
    end else if (clk_en) begin
      enable_word_r <= enable_word_nxt;
    end
  end

  // ----------------------------------------
  // Over-current error flags
  // ----------------------------------------
  // A flag stays up after the fault goes away; only its own clear lowers it.
  // The clear is decoded per channel in the loop above.
  always_comb begin
    // Set wins over clear so an over-current in the clear cycle is kept
    oc_flag_nxt = (oc_flag_r & ~clr_mask) | chan_status.overcurrent;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_flag_r <= '0;
    end else if (clk_en) begin
      oc_flag_r <= oc_flag_nxt;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Colliding read strobes resolve in a fixed order; the others are dropped
  always_comb begin
    rd_src = HPCS_RD_IDLE;
    if (read_upstream_selection) begin
      rd_src = HPCS_RD_SELECTION;
    end else if (read_port_enable_word) begin
      rd_src = HPCS_RD_ENABLE;
    end else if (read_port_state_bank) begin
      rd_src = HPCS_RD_STATE;
    end else if (read_overcurrent_bank) begin
      rd_src = HPCS_RD_OVERCURRENT;
    end else if (read_subsystem_temperature) begin
      rd_src = HPCS_RD_TEMPERATURE;
    end
  end

  // Sign-extended so a reading below zero stays negative in the wide word;
  // a narrower sensor therefore costs nothing on the read path
  assign temp_word = WORD_W'(temperature_micro_c);

  // Read data holds until the next read so a slow consumer can still take it
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    unique case (rd_src)
      HPCS_RD_IDLE: begin
        // Idle keeps the last answer on rdata
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
      end
      HPCS_RD_SELECTION: begin
        rdata_nxt = {24'h00_0000, up_sel_r};
        rvalid_nxt = 1'b1;
      end
      HPCS_RD_ENABLE: begin
        rdata_nxt = enable_word_r;
        rvalid_nxt = 1'b1;
      end
      HPCS_RD_STATE: begin
        rdata_nxt = state_bank[bank_index];
        rvalid_nxt = 1'b1;
      end
      HPCS_RD_OVERCURRENT: begin
        rdata_nxt = oc_bank[bank_index];
        rvalid_nxt = 1'b1;
      end
      HPCS_RD_TEMPERATURE: begin
        rdata_nxt = temp_word;
        rvalid_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rdata_valid = rvalid_r;

  // ----------------------------------------
  // Upstream routing
  // ----------------------------------------
  hpcs_upstream_t active_up;

  always_comb begin
    unique case (up_sel_r)
      UP_SEL_FIRST: active_up = HPCS_UP_FIRST;
      UP_SEL_SECOND: active_up = HPCS_UP_SECOND;
      UP_SEL_AUTOMATIC: begin
        active_up = upstream0_vbus_present ? HPCS_UP_FIRST : HPCS_UP_SECOND;
      end
      UP_SEL_DISCONNECT: active_up = HPCS_UP_NONE;
      default: active_up = HPCS_UP_NONE;
    endcase
  end

  // Hub traffic goes to the chosen upstream only; nothing is connected in reset.
  // The control port never appears in the hub-traffic path.
  assign upstream0_connect = rst_n && (active_up == HPCS_UP_FIRST);
  assign upstream1_connect = rst_n && (active_up == HPCS_UP_SECOND);

  // ----------------------------------------
  // Management routing
  // ----------------------------------------
  // A plugged control cable takes management away from both upstreams, even
  // while the selected upstream is live
  assign mgmt_via_control_port = control_cable_present;
  assign mgmt_via_upstream0 = !control_cable_present && upstream0_connect;
  assign mgmt_via_upstream1 = !control_cable_present && upstream1_connect;
endmodule // hpcs_top
